// ==== hw/ppcb_regs.vh ====
// register map and reset values for the port pin configuration bank
`ifndef PPCB_REGS_VH
`define PPCB_REGS_VH
`define PPCB_PAGE_ALL 4'hf
`define PPCB_PAGE_CFG 4'h0
`define PPCB_PAGE_DRV 4'hf
`define PPCB_ADDR_P2_LATCH 8'ha0
`define PPCB_ADDR_P1_OTYPE 8'ha5
`define PPCB_ADDR_P1_DRIVE 8'ha5
`define PPCB_ADDR_P2_OTYPE 8'ha6
`define PPCB_ADDR_P2_DRIVE 8'ha6
`define PPCB_ADDR_P1_BYPASS 8'hd5
`define PPCB_ADDR_P2_BYPASS 8'hd6
`define PPCB_ADDR_P1_ADSEL 8'hf2
`define PPCB_ADDR_P2_ADSEL 8'hf3
`define PPCB_RST_LATCH 8'hff
`define PPCB_RST_ADSEL 8'hff
`define PPCB_RST_OTYPE 8'h00
`define PPCB_RST_BYPASS 8'h00
`define PPCB_RST_DRIVE 8'h00
`define PPCB_BIT_BASE_P2 8'ha0
`endif

// ==== hw/ppcb_pin_ctrl.v ====
// per-port pin driver control derived from configuration bits
`timescale 1ns/10ps
`default_nettype none
module ppcb_pin_ctrl #(
  parameter WIDTH = 8
) (
  input wire i_clock,
  input wire i_rst,
  input wire [WIDTH-1:0] i_latch,
  input wire [WIDTH-1:0] i_adsel,
  input wire [WIDTH-1:0] i_otype,
  input wire [WIDTH-1:0] i_present,
  input wire [WIDTH-1:0] i_pin,
  output reg [WIDTH-1:0] o_out,
  output reg [WIDTH-1:0] o_oe,
  output reg [WIDTH-1:0] o_pullup_en,
  output reg [WIDTH-1:0] o_rx_en,
  output wire [WIDTH-1:0] o_pin_sync
);
  reg [WIDTH-1:0] meta_r;
  reg [WIDTH-1:0] sync_r;
  // analog pins read low: receiver is off
  assign o_pin_sync = sync_r & i_adsel & i_present;
  ////////////////////////////////////////////////////////////
  always @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      meta_r <= {WIDTH{1'b0}};
      sync_r <= {WIDTH{1'b0}};
      o_out <= {WIDTH{1'b0}};
      o_oe <= {WIDTH{1'b0}};
      o_pullup_en <= {WIDTH{1'b0}};
      o_rx_en <= {WIDTH{1'b0}};
    end else begin
      meta_r <= i_pin;
      // nothing but the second stage may look at the first
      sync_r <= meta_r;
      // level only where the pin may drive; analog and absent pins stay quiet
      o_out <= i_latch & i_otype & i_adsel & i_present;
      // low always driven; high driven only push-pull; analog and absent never
      o_oe <= i_adsel & i_present & (~i_latch | i_otype);
      o_pullup_en <= i_adsel & i_present & ~i_otype & i_latch;
      o_rx_en <= i_adsel & i_present;
    end
  end
endmodule // ppcb_pin_ctrl
`default_nettype wire

// ==== hw/ppcb_bank.v ====
// port 1/2 configuration registers, port 2 latch and pin control
`timescale 1ns/10ps
`default_nettype none
`include "ppcb_regs.vh"
// Functional notes
// - analog input mode disables pullup, digital driver and digital receiver.
// - input-mode bit 0 is analog, 1 digital; resets to 1.
// - output-mode bit 0 is open-drain, 1 push-pull; resets to 0.
// - skip bit 1 makes crossbar pass over pin; resets to 0.
// - drive bit 0 selects low drive, 1 high drive; resets to 0.
// - writing port 2 latch loads output value for digital pins.
// - reading port 2 latch returns sampled pin levels.
// - latch 0 drives low; 1 drives high or floats; resets to 1.
// - port 2 latch reachable on every page and bit-addressable.
// - port 1 has eight pins large package, seven small.
// - port 2 has eight pins large package, only bit 7 small.
module ppcb_bank #(
  parameter SMALL_PKG = 0
) (
  input wire i_clock,
  input wire i_rst,
  input wire [3:0] i_sfr_page,
  input wire [7:0] i_sfr_addr,
  input wire i_sfr_wr,
  input wire i_sfr_rd,
  input wire [7:0] i_sfr_wdata,
  input wire i_bit_wr,
  input wire [7:0] i_bit_addr,
  input wire i_bit_val,
  input wire [7:0] i_p1_pin,
  input wire [7:0] i_p2_pin,
  output reg [7:0] o_sfr_rdata,
  output reg o_sfr_hit,
  output wire [7:0] o_p1_out,
  output wire [7:0] o_p1_oe,
  output wire [7:0] o_p1_pullup_en,
  output wire [7:0] o_p1_rx_en,
  output reg [7:0] o_p1_high_drive,
  output reg [7:0] o_p1_skip,
  output wire [7:0] o_p2_out,
  output wire [7:0] o_p2_oe,
  output wire [7:0] o_p2_pullup_en,
  output wire [7:0] o_p2_rx_en,
  output reg [7:0] o_p2_high_drive,
  output reg [7:0] o_p2_skip,
  input wire [7:0] i_p1_latch
);
  reg [7:0] p2_latch_r;
  reg [7:0] p1_adsel_r;
  reg [7:0] p2_adsel_r;
  reg [7:0] p1_otype_r;
  reg [7:0] p2_otype_r;
  reg [7:0] p1_drive_r;
  reg [7:0] p2_drive_r;
  reg [7:0] p1_bypass_r;
  reg [7:0] p2_bypass_r;
  reg [7:0] rdata_nxt;
  reg hit_nxt;
  wire [7:0] p1_sync;
  wire [7:0] p2_sync;
  wire pg_cfg;
  wire pg_drv;
  wire bit_hit;
  wire [7:0] p1_present;
  wire [7:0] p2_present;
  // per-register write strobes, decoded once
  wire we_p2_latch;
  wire we_p1_adsel;
  wire we_p2_adsel;
  wire we_p1_otype;
  wire we_p2_otype;
  wire we_p1_bypass;
  wire we_p2_bypass;
  wire we_p1_drive;
  wire we_p2_drive;
  wire [2:0] bit_sel;
  localparam [7:0] BIT_BASE = `PPCB_BIT_BASE_P2;
  // package option only narrows pins, registers stay full width
  assign p1_present = (SMALL_PKG != 0) ? 8'h7f : 8'hff;
  assign p2_present = (SMALL_PKG != 0) ? 8'h80 : 8'hff;
  assign pg_cfg = (i_sfr_page == `PPCB_PAGE_CFG);
  assign pg_drv = (i_sfr_page == `PPCB_PAGE_DRV);
  // latch bits sit at bit addresses a0..a7, any page
  assign bit_hit = i_bit_wr && (i_bit_addr[7:3] == BIT_BASE[7:3]);
  assign bit_sel = i_bit_addr[2:0];
  ////////////////////////////////////////////////////////////
  // configuration sits on page 0, drive strength on page f
  // drive and output type share offsets, so the page alone picks
  assign we_p2_latch = i_sfr_wr && (i_sfr_addr == `PPCB_ADDR_P2_LATCH);
  assign we_p1_adsel = i_sfr_wr && pg_cfg && (i_sfr_addr == `PPCB_ADDR_P1_ADSEL);
  assign we_p2_adsel = i_sfr_wr && pg_cfg && (i_sfr_addr == `PPCB_ADDR_P2_ADSEL);
  assign we_p1_otype = i_sfr_wr && pg_cfg && (i_sfr_addr == `PPCB_ADDR_P1_OTYPE);
  assign we_p2_otype = i_sfr_wr && pg_cfg && (i_sfr_addr == `PPCB_ADDR_P2_OTYPE);
  assign we_p1_bypass = i_sfr_wr && pg_cfg && (i_sfr_addr == `PPCB_ADDR_P1_BYPASS);
  assign we_p2_bypass = i_sfr_wr && pg_cfg && (i_sfr_addr == `PPCB_ADDR_P2_BYPASS);
  assign we_p1_drive = i_sfr_wr && pg_drv && (i_sfr_addr == `PPCB_ADDR_P1_DRIVE);
  assign we_p2_drive = i_sfr_wr && pg_drv && (i_sfr_addr == `PPCB_ADDR_P2_DRIVE);
  ////////////////////////////////////////////////////////////
  always @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      p2_latch_r <= `PPCB_RST_LATCH;
      p1_adsel_r <= `PPCB_RST_ADSEL;
      p2_adsel_r <= `PPCB_RST_ADSEL;
      p1_otype_r <= `PPCB_RST_OTYPE;
      p2_otype_r <= `PPCB_RST_OTYPE;
      p1_drive_r <= `PPCB_RST_DRIVE;
      p2_drive_r <= `PPCB_RST_DRIVE;
      p1_bypass_r <= `PPCB_RST_BYPASS;
      p2_bypass_r <= `PPCB_RST_BYPASS;
    end else begin
      // a byte write beats a bit write landing in the same cycle
      if (we_p2_latch) begin
        p2_latch_r <= i_sfr_wdata;
      end else if (bit_hit) begin
        p2_latch_r[bit_sel] <= i_bit_val;
      end
      if (we_p1_adsel) begin
        p1_adsel_r <= i_sfr_wdata;
      end
      if (we_p2_adsel) begin
        p2_adsel_r <= i_sfr_wdata;
      end
      if (we_p1_otype) begin
        p1_otype_r <= i_sfr_wdata;
      end
      if (we_p2_otype) begin
        p2_otype_r <= i_sfr_wdata;
      end
      if (we_p1_bypass) begin
        p1_bypass_r <= i_sfr_wdata;
      end
      if (we_p2_bypass) begin
        p2_bypass_r <= i_sfr_wdata;
      end
      // drive registers share offsets with output type on the other page
      if (we_p1_drive) begin
        p1_drive_r <= i_sfr_wdata;
      end
      if (we_p2_drive) begin
        p2_drive_r <= i_sfr_wdata;
      end
    end
  end
  ////////////////////////////////////////////////////////////
  always @* begin
    rdata_nxt = 8'h00;
    hit_nxt = 1'b1;
    // the latch address reads the synchronised pins, on any page
    if (i_sfr_addr == `PPCB_ADDR_P2_LATCH) begin
      rdata_nxt = p2_sync;
    end else if (pg_cfg) begin
      case (i_sfr_addr)
        `PPCB_ADDR_P1_ADSEL: rdata_nxt = p1_adsel_r;
        `PPCB_ADDR_P2_ADSEL: rdata_nxt = p2_adsel_r;
        `PPCB_ADDR_P1_OTYPE: rdata_nxt = p1_otype_r;
        `PPCB_ADDR_P2_OTYPE: rdata_nxt = p2_otype_r;
        `PPCB_ADDR_P1_BYPASS: rdata_nxt = p1_bypass_r;
        `PPCB_ADDR_P2_BYPASS: rdata_nxt = p2_bypass_r;
        default: hit_nxt = 1'b0;
      endcase
    end else if (pg_drv) begin
      case (i_sfr_addr)
        `PPCB_ADDR_P1_DRIVE: rdata_nxt = p1_drive_r;
        `PPCB_ADDR_P2_DRIVE: rdata_nxt = p2_drive_r;
        default: hit_nxt = 1'b0;
      endcase
    end else begin
      hit_nxt = 1'b0;
    end
  end
  ////////////////////////////////////////////////////////////
  // registered read port: data one cycle after the read strobe
  always @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_sfr_rdata <= 8'h00;
      o_sfr_hit <= 1'b0;
      o_p1_high_drive <= 8'h00;
      o_p2_high_drive <= 8'h00;
      o_p1_skip <= 8'h00;
      o_p2_skip <= 8'h00;
    end else begin
      o_sfr_rdata <= i_sfr_rd ? rdata_nxt : 8'h00;
      o_sfr_hit <= i_sfr_rd & hit_nxt;
      o_p1_high_drive <= p1_drive_r & p1_present;
      o_p2_high_drive <= p2_drive_r & p2_present;
      // absent pins reported skipped so the crossbar never lands on them
      o_p1_skip <= p1_bypass_r | ~p1_present;
      o_p2_skip <= p2_bypass_r | ~p2_present;
    end
  end
  ////////////////////////////////////////////////////////////
  ppcb_pin_ctrl #(.WIDTH(8)) u_p1 (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_latch(i_p1_latch),
    .i_adsel(p1_adsel_r),
    .i_otype(p1_otype_r),
    .i_present(p1_present),
    .i_pin(i_p1_pin),
    .o_out(o_p1_out),
    .o_oe(o_p1_oe),
    .o_pullup_en(o_p1_pullup_en),
    .o_rx_en(o_p1_rx_en),
    .o_pin_sync(p1_sync)
  );
  ppcb_pin_ctrl #(.WIDTH(8)) u_p2 (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_latch(p2_latch_r),
    .i_adsel(p2_adsel_r),
    .i_otype(p2_otype_r),
    .i_present(p2_present),
    .i_pin(i_p2_pin),
    .o_out(o_p2_out),
    .o_oe(o_p2_oe),
    .o_pullup_en(o_p2_pullup_en),
    .o_rx_en(o_p2_rx_en),
    .o_pin_sync(p2_sync)
  );
endmodule // ppcb_bank
`default_nettype wire

// ==== sim/ppcb_chk.sv ====
// port-level checker for the port pin configuration bank
`timescale 1ns/10ps
`default_nettype none
module ppcb_chk #(
  parameter SMALL_PKG = 0
) (
  input wire i_clock,
  input wire i_rst,
  input wire [3:0] i_sfr_page,
  input wire [7:0] i_sfr_addr,
  input wire i_sfr_wr,
  input wire i_sfr_rd,
  input wire [7:0] i_sfr_wdata,
  input wire i_bit_wr,
  input wire [7:0] o_sfr_rdata,
  input wire o_sfr_hit,
  input wire [7:0] o_p1_oe,
  input wire [7:0] o_p1_pullup_en,
  input wire [7:0] o_p1_rx_en,
  input wire [7:0] o_p2_out,
  input wire [7:0] o_p2_oe,
  input wire [7:0] o_p2_pullup_en,
  input wire [7:0] o_p2_rx_en,
  input wire [7:0] o_p2_high_drive,
  input wire [7:0] o_p2_skip
);
  localparam logic [7:0] P2_PRESENT = (SMALL_PKG != 0) ? 8'h80 : 8'hff;
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_rst);
  ////////////////////////////////////////////////////////////////
  sequence lat_clr;
    i_sfr_wr && i_sfr_addr == 8'ha0 && i_sfr_wdata == 8'h00;
  endsequence
  sequence lat_hold;
    !i_bit_wr && !(i_sfr_wr && i_sfr_addr == 8'ha0);
  endsequence
  ////////////////////////////////////////////////////////////////
  p2_gate_a: assert property (((o_p2_pullup_en | o_p2_oe) & ~o_p2_rx_en) == 8'h00)
    else $error("p2 analog pin active");
  p1_gate_a: assert property (((o_p1_pullup_en | o_p1_oe) & ~o_p1_rx_en) == 8'h00)
    else $error("p1 analog pin active");
  drive_pair_a: assert property ((o_p2_out & ~o_p2_oe) == 8'h00 && (o_p2_pullup_en & o_p2_oe) == 8'h00)
    else $error("p2 drive and pullup clash");
  read_hit_a: assert property (i_sfr_rd && i_sfr_page == 4'h0 && i_sfr_addr == 8'hf2 |=> o_sfr_hit)
    else $error("mapped read without hit");
  idle_read_a: assert property (!i_sfr_rd |=> o_sfr_rdata == 8'h00 && !o_sfr_hit)
    else $error("read data without read");
  unmapped_a: assert property (i_sfr_rd && i_sfr_addr == 8'h00 |=> !o_sfr_hit)
    else $error("unmapped read hit");
  latch_low_a: assert property (lat_clr ##1 lat_hold |=> o_p2_out == 8'h00 && o_p2_pullup_en == 8'h00)
    else $error("cleared latch not driving low");
  skip_load_a: assert property (i_sfr_wr && i_sfr_page == 4'h0 && i_sfr_addr == 8'hd6
    ##1 !(i_sfr_wr && i_sfr_addr == 8'hd6) |=> o_p2_skip == ($past(i_sfr_wdata, 2) | ~P2_PRESENT))
    else $error("skip not loaded");
  drive_load_a: assert property (i_sfr_wr && i_sfr_page == 4'hf && i_sfr_addr == 8'ha6
    ##1 !(i_sfr_wr && i_sfr_addr == 8'ha6) |=> o_p2_high_drive == ($past(i_sfr_wdata, 2) & P2_PRESENT))
    else $error("drive not loaded");
endmodule // ppcb_chk
bind ppcb_bank ppcb_chk #(.SMALL_PKG(SMALL_PKG)) u_chk (.*);
`default_nettype wire

// ==== sim/ppcb_pins.sv ====
// pin wire model: module drive, outside drive, pullup or floating
`timescale 1ns/10ps
`default_nettype none
module ppcb_pins (
  input wire i_clock,
  input wire [7:0] i_oe,
  input wire [7:0] i_out,
  input wire [7:0] i_pullup,
  input wire [7:0] i_ext_en,
  input wire [7:0] i_ext,
  output wire [7:0] o_pin
);
  logic tog_r = 1'b0;
  // a floating line never holds its last value
  always @(posedge i_clock) tog_r <= ~tog_r;
  assign o_pin = (i_oe & i_out) | (~i_oe & i_ext_en & i_ext) | (~i_oe & ~i_ext_en & (i_pullup | {8{tog_r}}));
endmodule // ppcb_pins
`default_nettype wire

// ==== sim/tb.sv ====
// testbench for the port pin configuration bank
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, s) begin n_tests++; if ((s) !== (e)) begin num_errors++; $display("Error %s exp %h got %h", n, e, s); end end
module tb;
  logic i_clock = 0, i_rst = 1, i_sfr_wr = 0, i_sfr_rd = 0, i_bit_wr = 0, i_bit_val = 0;
  logic [3:0] i_sfr_page = 0;
  logic [7:0] i_sfr_addr = 0, i_sfr_wdata = 0, i_bit_addr = 0, ext_en = 0, ext = 0, i_p1_latch = 8'hff;
  wire [7:0] o_sfr_rdata, o_p1_out, o_p1_oe, o_p1_pullup_en, o_p1_rx_en, o_p1_high_drive, o_p1_skip;
  wire [7:0] o_p2_out, o_p2_oe, o_p2_pullup_en, o_p2_rx_en, o_p2_high_drive, o_p2_skip, i_p1_pin, i_p2_pin;
  wire o_sfr_hit;
  int num_errors = 0, n_tests = 0;
  always #2 i_clock = ~i_clock;
  ppcb_bank u_dut (.*);
  ppcb_pins u_p1 (.i_clock, .i_oe(o_p1_oe), .i_out(o_p1_out), .i_pullup(o_p1_pullup_en), .i_ext_en(ext_en),
    .i_ext(ext), .o_pin(i_p1_pin));
  ppcb_pins u_p2 (.i_clock, .i_oe(o_p2_oe), .i_out(o_p2_out), .i_pullup(o_p2_pullup_en), .i_ext_en(ext_en),
    .i_ext(ext), .o_pin(i_p2_pin));
  wire [7:0] s_rdata, s_p1_rx, s_p1_skip, s_p2_rx, s_p2_skip, s_p2_pullup, s_p2_drive;
  ppcb_bank #(.SMALL_PKG(1)) u_dut_small (.*, .o_sfr_rdata(s_rdata), .o_sfr_hit(), .o_p1_out(), .o_p1_oe(),
    .o_p1_pullup_en(), .o_p1_rx_en(s_p1_rx), .o_p1_high_drive(), .o_p1_skip(s_p1_skip), .o_p2_out(), .o_p2_oe(),
    .o_p2_pullup_en(s_p2_pullup), .o_p2_rx_en(s_p2_rx), .o_p2_high_drive(s_p2_drive), .o_p2_skip(s_p2_skip));
  ////////////////////////////////////////////////////////////////
  task automatic wr(input logic [3:0] p, input logic [7:0] a, d);
    @(negedge i_clock);
    {i_sfr_page, i_sfr_addr, i_sfr_wdata, i_sfr_wr} = {p, a, d, 1'b1};
    @(negedge i_clock);
    i_sfr_wr = 0;
  endtask
  task automatic rd(input logic [3:0] p, input logic [7:0] a, e, input logic h);
    @(negedge i_clock);
    {i_sfr_page, i_sfr_addr, i_sfr_rd} = {p, a, 1'b1};
    @(negedge i_clock);
    i_sfr_rd = 0;
    `CHK("rdata", e, o_sfr_rdata);
    `CHK("hit", h, o_sfr_hit);
  endtask
  task automatic stop_test;
    if (num_errors == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rd(0, 8'hf2, 8'hff, 1);
    rd(0, 8'hf3, 8'hff, 1);
    rd(3, 8'hf2, 8'h00, 0);
    rd(0, 8'ha5, 8'h00, 1);
    rd(0, 8'ha6, 8'h00, 1);
    rd(4'hf, 8'ha5, 8'h00, 1);
    rd(4'hf, 8'ha6, 8'h00, 1);
    rd(0, 8'hd5, 8'h00, 1);
    rd(0, 8'hd6, 8'h00, 1);
    rd(0, 8'h00, 8'h00, 0);
    rd(3, 8'ha0, 8'hff, 1);
    `CHK("small p2 read", 8'h80, s_rdata);
    `CHK("small p1 rx", 8'h7f, s_p1_rx);
    `CHK("small p1 skip", 8'h80, s_p1_skip);
    `CHK("small p2 rx", 8'h80, s_p2_rx);
    `CHK("small p2 skip", 8'h7f, s_p2_skip);
    `CHK("small p2 pullup", 8'h80, s_p2_pullup);
    `CHK("p2 pullup", 8'hff, o_p2_pullup_en);
  endtask
  task automatic t_cfg;
    wr(0, 8'ha6, 8'h5a);
    wr(4'hf, 8'ha6, 8'h3c);
    wr(0, 8'hd6, 8'hc3);
    wr(4'hf, 8'ha5, 8'h0f);
    wr(0, 8'hd5, 8'h81);
    wr(0, 8'ha5, 8'h33);
    rd(0, 8'ha6, 8'h5a, 1);
    rd(4'hf, 8'ha6, 8'h3c, 1);
    `CHK("small drive reg", 8'h3c, s_rdata);
    `CHK("small p2 drive", 8'h00, s_p2_drive);
    rd(0, 8'ha5, 8'h33, 1);
    `CHK("p1 out", 8'h33, o_p1_out);
    `CHK("p1 oe", 8'h33, o_p1_oe);
    `CHK("p1 pullup", 8'hcc, o_p1_pullup_en);
    `CHK("p2 skip", 8'hc3, o_p2_skip);
    `CHK("p2 drive", 8'h3c, o_p2_high_drive);
    `CHK("p1 drive", 8'h0f, o_p1_high_drive);
    `CHK("p1 skip", 8'h81, o_p1_skip);
  endtask
  task automatic t_latch;
    wr(7, 8'ha0, 8'hf0);
    repeat (2) @(negedge i_clock);
    `CHK("p2 oe", 8'h5f, o_p2_oe);
    `CHK("p2 out", 8'h50, o_p2_out);
    `CHK("p2 pullup", 8'ha0, o_p2_pullup_en);
    {i_bit_addr, i_bit_val, i_bit_wr} = {8'ha2, 1'b1, 1'b1};
    @(negedge i_clock);
    i_bit_wr = 0;
    repeat (5) @(negedge i_clock);
    rd(0, 8'ha0, 8'hf4, 1);
    wr(2, 8'ha0, 8'h00);
    repeat (2) @(negedge i_clock);
    `CHK("p2 out low", 8'h00, o_p2_out);
  endtask
  task automatic t_analog;
    wr(0, 8'hf3, 8'h0f);
    {ext_en, ext} = {8'hf0, 8'hf0};
    repeat (5) @(negedge i_clock);
    `CHK("p2 rx", 8'h0f, o_p2_rx_en);
    `CHK("p2 analog off", 8'h00, (o_p2_oe | o_p2_pullup_en) & 8'hf0);
    rd(0, 8'ha0, 8'h00, 1);
    wr(0, 8'hf2, 8'h00);
    repeat (2) @(negedge i_clock);
    `CHK("p1 rx", 8'h00, o_p1_rx_en);
    `CHK("p1 analog off", 8'h00, o_p1_oe | o_p1_pullup_en);
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    #100000;
    num_errors++;
    stop_test;
  end
  initial begin
    repeat (5) @(negedge i_clock);
    i_rst = 0;
    t_reset;
    t_cfg;
    t_latch;
    t_analog;
    stop_test;
  end
endmodule // tb
`default_nettype wire
